// ### dv/basic_interval_timer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module basic_interval_timer_bench
    import bit_pkg::*;
;
    localparam logic [31:0] S_EN = 32'h1 << SETUP_ENABLE_BIT;
    localparam logic [31:0] S_UP = 32'h1 << SETUP_COUNT_UP_BIT;
    localparam logic [31:0] S_AUTO = 32'h1 << SETUP_AUTO_RESTART_BIT;
    localparam logic [31:0] S_SOFT = 32'h1 << SETUP_SOFT_RESET_BIT;
    localparam logic [31:0] S_START = 32'h1 << SETUP_START_BIT;
    localparam logic [31:0] S_RELOAD = 32'h1 << SETUP_RELOAD_BIT;
    localparam logic [31:0] S_HALT = 32'h1 << SETUP_HALT_BIT;
    localparam logic [31:0] S_PRE2 = 32'h2 << SETUP_PRESCALE_LSB;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, idle;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0] pstrb;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    bit_timer #(.CNT_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .idle(idle));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("counts: tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        logic [31:0] q;
        logic e;
        rd(OFS_CURRENT_COUNT, 32'h0);
        rd(OFS_RESTART_VALUE, 32'h0);
        rd(OFS_LIMIT_FLAG_STATUS, 32'h0);
        rd(OFS_LIMIT_IRQ_MASK, 32'h0);
        rd(OFS_TIMER_SETUP, 32'h0);
        xfer(1'b0, 8'h14, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        chk({30'h0, irq, idle}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        $display("done: reset values");
    endtask

    task automatic t_up_oneshot();
        wr(OFS_LIMIT_IRQ_MASK, 32'h1);
        wr(OFS_CURRENT_COUNT, 32'h0000_FFFE);
        rd(OFS_CURRENT_COUNT, 32'h0000_FFFE);
        wr(OFS_TIMER_SETUP, S_EN | S_UP | S_START);
        repeat (4) @(posedge pclk);
        rd(OFS_CURRENT_COUNT, 32'h0);
        rd(OFS_LIMIT_FLAG_STATUS, 32'h1);
        rd(OFS_TIMER_SETUP, S_EN | S_UP);
        chk({30'h0, irq, idle}, 32'h3);
        wr(OFS_LIMIT_FLAG_STATUS, 32'h1);
        rd(OFS_LIMIT_FLAG_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("done: up one-shot");
    endtask

    task automatic t_down_masked();
        wr(OFS_LIMIT_IRQ_MASK, 32'h0);
        wr(OFS_CURRENT_COUNT, 32'h0);
        wr(OFS_TIMER_SETUP, S_EN | S_START);
        rd(OFS_CURRENT_COUNT, 32'h0000_FFFF);
        rd(OFS_LIMIT_FLAG_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_LIMIT_FLAG_STATUS, 32'h1);
        $display("done: down masked");
    endtask

    task automatic t_continuous();
        int n;
        logic [31:0] q1, q2;
        logic e;
        wr(OFS_LIMIT_IRQ_MASK, 32'h1);
        wr(OFS_RESTART_VALUE, 32'h3);
        wr(OFS_CURRENT_COUNT, 32'h1);
        wr(OFS_TIMER_SETUP, S_PRE2 | S_EN | S_AUTO | S_START);
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            @(negedge pclk);
            n++;
        end
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        n = 1;
        while (irq !== 1'b1 && n < 100)
        begin
            @(negedge pclk);
            n++;
        end
        chk(n, 32'd12);
        rd(OFS_CURRENT_COUNT, 32'h3);
        wr(OFS_TIMER_SETUP, S_PRE2 | S_EN | S_AUTO | S_START | S_HALT);
        @(posedge pclk);
        chk({31'h0, idle}, 32'h1);
        xfer(1'b0, OFS_CURRENT_COUNT, 32'h0, q1, e);
        repeat (20) @(posedge pclk);
        xfer(1'b0, OFS_CURRENT_COUNT, 32'h0, q2, e);
        chk(q1, 32'h1);
        chk(q2, q1);
        wr(OFS_TIMER_SETUP, S_PRE2 | S_EN | S_AUTO | S_START);
        repeat (2) @(posedge pclk);
        rd(OFS_CURRENT_COUNT, 32'h0);
        $display("done: continuous");
    endtask

    task automatic t_reload();
        wr(OFS_RESTART_VALUE, 32'h100);
        wr(OFS_TIMER_SETUP, S_EN | S_START | S_HALT);
        wr(OFS_TIMER_SETUP, S_EN | S_START | S_HALT | S_RELOAD);
        rd(OFS_CURRENT_COUNT, 32'h100);
        rd(OFS_TIMER_SETUP, S_EN | S_START | S_HALT);
        wr(OFS_TIMER_SETUP, S_EN);
        wr(OFS_CURRENT_COUNT, 32'h10);
        wr(OFS_TIMER_SETUP, S_EN | S_RELOAD);
        rd(OFS_CURRENT_COUNT, 32'h10);
        $display("done: reload");
    endtask

    task automatic t_resets();
        wr(OFS_LIMIT_IRQ_MASK, 32'h1);
        wr(OFS_RESTART_VALUE, 32'h55);
        wr(OFS_TIMER_SETUP, S_SOFT);
        repeat (2) @(posedge pclk);
        rd(OFS_CURRENT_COUNT, 32'h0);
        rd(OFS_RESTART_VALUE, 32'h0);
        rd(OFS_LIMIT_IRQ_MASK, 32'h0);
        rd(OFS_TIMER_SETUP, 32'h0);
        wr(OFS_LIMIT_IRQ_MASK, 32'h1);
        wr(OFS_TIMER_SETUP, S_EN | S_START);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({30'h0, irq, idle}, 32'h1);
        presetn <= 1'b1;
        rd(OFS_CURRENT_COUNT, 32'h0);
        rd(OFS_LIMIT_FLAG_STATUS, 32'h0);
        $display("done: resets");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_up_oneshot();
        t_down_masked();
        t_continuous();
        t_reload();
        t_resets();
        report_and_stop();
    end
endmodule // basic_interval_timer_bench
`default_nettype wire

// ### hdl/bit_pkg.sv
package bit_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CURRENT_COUNT = 8'h00;
    localparam logic [7:0] OFS_RESTART_VALUE = 8'h04;
    localparam logic [7:0] OFS_LIMIT_FLAG_STATUS = 8'h08;
    localparam logic [7:0] OFS_LIMIT_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_TIMER_SETUP = 8'h10;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int STAT_LIMIT_BIT = 0;
    localparam int MASK_LIMIT_BIT = 0;
    localparam int SETUP_ENABLE_BIT = 0;
    localparam int SETUP_COUNT_UP_BIT = 2;
    localparam int SETUP_AUTO_RESTART_BIT = 3;
    localparam int SETUP_SOFT_RESET_BIT = 4;
    localparam int SETUP_START_BIT = 5;
    localparam int SETUP_RELOAD_BIT = 6;
    localparam int SETUP_HALT_BIT = 7;
    localparam int SETUP_PRESCALE_LSB = 16;
    localparam int PRESCALE_W = 16;

    // ----------------------------------------
    // reset values and widths
    // ----------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] RESTART_RESET = 32'h0000_0000;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 16'h0000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ### hdl/bit_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module bit_prescaler
    import bit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic [PRESCALE_W-1:0] divide,
    output logic tick
);
    logic [PRESCALE_W-1:0] cnt;
    logic [PRESCALE_W-1:0] next_cnt;

    // ----------------------------------------
    // one enable every divide+1 clocks
    // ----------------------------------------
    assign tick = !clear && (cnt >= divide);

    always_comb
    begin
        if (clear || tick)
            next_cnt = '0;
        else
            next_cnt = cnt + PRESCALE_W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    a_zero_full_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (!clear && divide == '0) |-> tick)
        else $error("prescale zero must tick every clock");
endmodule // bit_prescaler
`default_nettype wire

// ### hdl/bit_timer.sv
`timescale 1ns/1ns
`default_nettype none
module bit_timer
    import bit_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic idle
);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] restart;
    logic [CNT_W-1:0] next_restart;
    logic flag;
    logic next_flag;
    logic irq_en;
    logic next_irq_en;
    logic enable;
    logic next_enable;
    logic count_up;
    logic next_count_up;
    logic auto_restart;
    logic next_auto_restart;
    logic start;
    logic next_start;
    logic halt;
    logic next_halt;
    logic [PRESCALE_W-1:0] prescale;
    logic [PRESCALE_W-1:0] next_prescale;
    logic soft_rst;
    logic next_soft_rst;
    logic [DATA_W-1:0] next_prdata;

    logic run;
    logic tick;
    logic at_limit;
    logic limit_event;
    logic wr;
    logic rd_setup;
    logic mapped;
    logic [DATA_W-1:0] wmerge_count;
    logic [DATA_W-1:0] wmerge_restart;
    logic wr_count;
    logic wr_setup;
    logic reload_req;
    logic flag_clear;

    if (CNT_W != 16 && CNT_W != 32)
    begin : g_bad_width
        $error("counter width must be 16 or 32");
    end

    function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] d, input logic [3:0] s);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[8*i +: 8] = d[8*i +: 8];
        return r;
    endfunction

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign pready = 1'b1;
    assign mapped = (paddr == OFS_CURRENT_COUNT) || (paddr == OFS_RESTART_VALUE) ||
        (paddr == OFS_LIMIT_FLAG_STATUS) || (paddr == OFS_LIMIT_IRQ_MASK) ||
        (paddr == OFS_TIMER_SETUP);
    assign pslverr = psel && penable && !mapped;
    assign wr = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_count = wr && (paddr == OFS_CURRENT_COUNT);
    assign wr_setup = wr && (paddr == OFS_TIMER_SETUP);
    assign wmerge_count = merge_bytes(DATA_W'(count), pwdata, pstrb);
    assign wmerge_restart = merge_bytes(DATA_W'(restart), pwdata, pstrb);
    assign reload_req = wr_setup && pstrb[0] && pwdata[SETUP_RELOAD_BIT];
    assign flag_clear = wr && (paddr == OFS_LIMIT_FLAG_STATUS) && pstrb[0] &&
        pwdata[STAT_LIMIT_BIT];

    // ----------------------------------------
    // run control and outputs
    // ----------------------------------------
    assign run = enable && start && !halt;
    assign idle = !enable || !start || halt;
    assign irq = flag && irq_en;
    assign at_limit = count_up ? (count == CNT_MAX) : (count == '0);
    assign limit_event = run && tick && at_limit;

    bit_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!run || soft_rst),
        .divide(prescale),
        .tick(tick)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_count = count;
        next_restart = restart;
        next_irq_en = irq_en;
        next_enable = enable;
        next_count_up = count_up;
        next_auto_restart = auto_restart;
        next_start = start;
        next_halt = halt;
        next_prescale = prescale;
        next_soft_rst = 1'b0;
        next_flag = auto_restart ? 1'b0 : flag;
        // counting
        if (run && tick)
        begin
            if (at_limit)
            begin
                if (auto_restart)
                    next_count = restart;
                else
                begin
                    next_count = count_up ? '0 : CNT_MAX;
                    next_start = 1'b0;
                end
            end
            else if (count_up)
                next_count = count + CNT_W'(1);
            else
                next_count = count - CNT_W'(1);
        end
        // software writes
        if (wr_count)
            next_count = wmerge_count[CNT_W-1:0];
        if (wr && paddr == OFS_RESTART_VALUE)
            next_restart = wmerge_restart[CNT_W-1:0];
        if (wr && paddr == OFS_LIMIT_IRQ_MASK && pstrb[0])
            next_irq_en = pwdata[MASK_LIMIT_BIT];
        if (wr_setup)
        begin
            if (pstrb[0])
            begin
                next_enable = pwdata[SETUP_ENABLE_BIT];
                next_count_up = pwdata[SETUP_COUNT_UP_BIT];
                next_auto_restart = pwdata[SETUP_AUTO_RESTART_BIT];
                next_start = pwdata[SETUP_START_BIT];
                next_halt = pwdata[SETUP_HALT_BIT];
                next_soft_rst = pwdata[SETUP_SOFT_RESET_BIT];
            end
            if (pstrb[2])
                next_prescale[7:0] = pwdata[SETUP_PRESCALE_LSB +: 8];
            if (pstrb[3])
                next_prescale[15:8] = pwdata[SETUP_PRESCALE_LSB + 8 +: 8];
        end
        if (reload_req && start)
            next_count = restart;
        if (flag_clear)
            next_flag = 1'b0;
        if (limit_event)
            next_flag = 1'b1;
    end

    // ----------------------------------------
    // read data, captured at setup
    // ----------------------------------------
    always_comb
    begin
        next_prdata = prdata;
        if (rd_setup)
        begin
            unique case (paddr)
                OFS_CURRENT_COUNT: next_prdata = DATA_W'(count);
                OFS_RESTART_VALUE: next_prdata = DATA_W'(restart);
                OFS_LIMIT_FLAG_STATUS: next_prdata = DATA_W'(flag);
                OFS_LIMIT_IRQ_MASK: next_prdata = DATA_W'(irq_en);
                OFS_TIMER_SETUP:
                    next_prdata = {prescale, 8'h00, halt, 1'b0, start, 1'b0,
                        auto_restart, count_up, 1'b0, enable};
                default: next_prdata = RDATA_ZERO;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            soft_rst <= 1'b0;
        else
            soft_rst <= next_soft_rst;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= COUNT_RESET[CNT_W-1:0];
            restart <= RESTART_RESET[CNT_W-1:0];
            flag <= 1'b0;
            irq_en <= 1'b0;
            enable <= 1'b0;
            count_up <= 1'b0;
            auto_restart <= 1'b0;
            start <= 1'b0;
            halt <= 1'b0;
            prescale <= PRESCALE_RESET;
            prdata <= RDATA_ZERO;
        end
        else if (soft_rst)
        begin
            count <= COUNT_RESET[CNT_W-1:0];
            restart <= RESTART_RESET[CNT_W-1:0];
            flag <= 1'b0;
            irq_en <= 1'b0;
            enable <= 1'b0;
            count_up <= 1'b0;
            auto_restart <= 1'b0;
            start <= 1'b0;
            halt <= 1'b0;
            prescale <= PRESCALE_RESET;
            prdata <= next_prdata;
        end
        else
        begin
            count <= next_count;
            restart <= next_restart;
            flag <= next_flag;
            irq_en <= next_irq_en;
            enable <= next_enable;
            count_up <= next_count_up;
            auto_restart <= next_auto_restart;
            start <= next_start;
            halt <= next_halt;
            prescale <= next_prescale;
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_quiet;
        !wr && !soft_rst;
    endsequence

    sequence s_step_up;
        (run && tick && count_up && !at_limit) and s_quiet;
    endsequence

    sequence s_step_down;
        (run && tick && !count_up && !at_limit) and s_quiet;
    endsequence

    a_irq_from_flag: assert property (irq == (flag && irq_en))
        else $error("irq not equal to gated flag");

    a_idle_when_halted: assert property (halt |-> idle)
        else $error("idle low while halted");

    a_count_up_step: assert property (s_step_up |=> count == $past(count) + CNT_W'(1))
        else $error("up count did not step by one");

    a_count_down_step: assert property (s_step_down |=> count == $past(count) - CNT_W'(1))
        else $error("down count did not step by one");

    a_oneshot_stop: assert property (((limit_event && !auto_restart) and s_quiet)
        |=> (!start && flag) ##1 (flag || $past(wr || soft_rst)))
        else $error("one-shot did not stop with level event");

    a_limit_wrap: assert property (((limit_event && !auto_restart) and s_quiet)
        |=> count == ($past(count_up) ? '0 : CNT_MAX))
        else $error("limit wrap value wrong");

    a_cont_restart: assert property (((limit_event && auto_restart) and s_quiet)
        |=> count == $past(restart) && flag && start)
        else $error("continuous mode did not restart from preload");

    a_cont_pulse: assert property (((flag && auto_restart && !limit_event) and s_quiet)
        |=> !flag)
        else $error("continuous event not a single pulse");

    a_halt_freeze: assert property ((halt and s_quiet) |=> $stable(count))
        else $error("count moved while halted");

    a_reload_count: assert property (reload_req && start && !soft_rst
        |=> count == $past(restart))
        else $error("reload did not load preload");

    a_soft_reset_all: assert property (soft_rst
        |=> count == '0 && !start && !enable && !flag && !irq_en)
        else $error("soft reset left state behind");

    a_read_snapshot: assert property (rd_setup && paddr == OFS_CURRENT_COUNT
        |=> prdata == DATA_W'($past(count)))
        else $error("count read not a snapshot");

    a_flag_set_wins: assert property (limit_event && flag_clear && !soft_rst
        |=> flag)
        else $error("event lost against clear");
endmodule // bit_timer
`default_nettype wire
